//--- hdl/clk_gate_regs.svh
// register map, field positions, reset values and keys of the clock gate block
// Function
// - bus gate bit 3 passes or stops the external bus controller clock.
// - bus gate bit 2 passes or stops the flash programming clock.
// - peripheral gate bit 28 passes or stops the converter clock.
// - peripheral gate bits 23 to 20 gate the four pwm pair clocks.
// - peripheral gate bits 17 and 16 gate serial port 1 and 0 clocks.
// - peripheral gate bits 13, 12 gate spi clocks; bit 8 gates i2c clock.
// - peripheral gate bit 6 gates the frequency divider clock.
// - peripheral gate bits 5 to 2 gate timers 3 to 0.
// - watchdog gate bit 0 changes only after unlock keys 59h, 16h, 88h.
// - switch fail flag sets on unstable target; write one clears it.
// - status bit 4 shows the fast oscillator stable.
// - status bit 3 shows the slow oscillator stable.
// - status bit 2 shows the pll stable.
// - status bit 0 shows the crystal stable.
// - protected tick source field bits 5:3 selects the tick reference.
// - protected core source field bits 2:0 selects the core bus clock.
// - core source field reloads from the boot configuration on every reset.
// - bits 31:30 select the pwm pair 1 clock source.
// - bits 29:28 select the pwm pair 0 clock; 00 is the crystal.
// - pwm pair 0 code 10 is core clock, 11 the fast oscillator.
`ifndef CLK_GATE_REGS_SVH
`define CLK_GATE_REGS_SVH

`define OFS_BUS_GATE 12'h004
`define OFS_PER_GATE 12'h008
`define OFS_STATUS 12'h00C
`define OFS_SEL0 12'h010
`define OFS_SEL1 12'h014
`define OFS_UNLOCK 12'h100

`define BUS_GATE_MASK 32'h0000_000C
`define BUS_GATE_RST 32'h0000_000C
`define PER_GATE_MASK 32'h10F3_317D
`define PER_GATE_RST 32'h0000_0000
`define TICK_SEL_RST 3'h7
`define PWM_SEL_RST 2'h3

`define POS_EXT_BUS 3
`define POS_FLASH 2
`define POS_ADC 28
`define POS_PWM0 20
`define POS_SER0 16
`define POS_SPI0 12
`define POS_I2C 8
`define POS_FDIV 6
`define POS_TMR0 2
`define POS_WDT 0
`define POS_FAIL 7

`define KEY_1 8'h59
`define KEY_2 8'h16
`define KEY_3 8'h88

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/clk_gate_pkg.sv
// types of the clock gate and source select block
package clk_gate_pkg;

    typedef enum logic [3:0] {
        ULK_IDLE = 4'b0001,
        ULK_KEY1 = 4'b0010,
        ULK_KEY2 = 4'b0100,
        ULK_OPEN = 4'b1000
    } unlock_state_t;

    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] bus_gate;
        logic [31:0] per_gate;
        logic [2:0] core_sel;
        logic [2:0] tick_sel;
        logic [1:0] pwm0_sel;
        logic [1:0] pwm1_sel;
        logic fail;
        logic [3:0] stable;
        unlock_state_t unlock;
    } ctl_state_t;

endpackage : clk_gate_pkg

//--- hdl/clock_gate_and_source_select.sv
// clock gates, source multiplexer selects and stability status behind axi4-lite
`timescale 1ns/10ps
`include "clk_gate_regs.svh"

module clock_gate_and_source_select
    import clk_gate_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic crystal_stable,
    input wire logic fast_rc_stable,
    input wire logic slow_rc_stable,
    input wire logic pll_locked_flag,
    input wire logic [2:0] boot_clock_config,
    output logic ext_bus_ctrl_clk_on,
    output logic flash_prog_clk_on,
    output logic adc_clk_on,
    output logic [3:0] pwm_pair_clk_on,
    output logic serial1_clk_on,
    output logic serial0_clk_on,
    output logic spi_ctrl1_clk_on,
    output logic spi_ctrl0_clk_on,
    output logic i2c_clk_on,
    output logic freq_divider_clk_on,
    output logic [3:0] timer_clk_on,
    output logic watchdog_clk_on,
    output logic [2:0] core_src_sel,
    output logic [2:0] tick_src_sel,
    output logic [1:0] pwm_pair0_src_sel,
    output logic [1:0] pwm_pair1_src_sel,
    output logic switch_fail_flag,
    output logic regs_unlocked
);

    ctl_state_t state_ff;
    ctl_state_t nxt_state;
    logic do_wr;
    logic fail_event;

    ////////////////////////////////////////////////////////////////////////////
    // source checks: {legal code, target stable}

    function automatic logic [1:0] core_check(input logic [2:0] code,
                                              input logic [3:0] stb);
        logic [1:0] r;
        r = 2'b00;
        unique casez (code)
            3'b000: r = {1'b1, stb[0]};
            3'b010: r = {1'b1, stb[1]};
            3'b011: r = {1'b1, stb[2]};
            3'b1??: r = {1'b1, stb[3]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction : core_check

    function automatic logic [1:0] tick_check(input logic [2:0] code,
                                              input logic [3:0] stb);
        logic [1:0] r;
        r = 2'b00;
        unique casez (code)
            3'b000: r = {1'b1, stb[0]};
            3'b010: r = {1'b1, stb[0]};
            3'b011: r = 2'b11;
            3'b1??: r = {1'b1, stb[3]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction : tick_check

    function automatic logic [1:0] pwm_check(input logic [1:0] code,
                                             input logic [3:0] stb);
        logic [1:0] r;
        r = 2'b00;
        unique case (code)
            2'b00: r = {1'b1, stb[0]};
            2'b10: r = 2'b11;
            2'b11: r = {1'b1, stb[3]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction : pwm_check

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign do_wr = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;

    always_comb begin
        logic [31:0] bmask;
        logic [31:0] m;
        logic [31:0] d;
        logic [31:0] rd_word;
        logic rd_hit;
        logic set_fail;
        logic clr_fail;
        logic [1:0] ck;
        bmask = '0;
        m = '0;
        d = state_ff.w_data;
        rd_word = '0;
        rd_hit = 1'b1;
        set_fail = 1'b0;
        clr_fail = 1'b0;
        ck = 2'b00;
        nxt_state = state_ff;
        nxt_state.stable = {fast_rc_stable, slow_rc_stable, pll_locked_flag, crystal_stable};
        for (int i = 0; i < 4; i++) begin
            bmask[i*8 +: 8] = {8{state_ff.w_strb[i]}};
        end

        // address and data taken in either order
        if (awvalid && !state_ff.aw_held) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = awaddr[11:0];
        end
        if (wvalid && !state_ff.w_held) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = wdata;
            nxt_state.w_strb = wstrb;
        end
        if (state_ff.bvalid && bready) begin
            nxt_state.bvalid = 1'b0;
        end

        if (do_wr) begin
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = `RESP_OKAY;
            unique case (state_ff.aw_addr)
                `OFS_BUS_GATE: begin
                    m = bmask & `BUS_GATE_MASK;
                    nxt_state.bus_gate = (state_ff.bus_gate & ~m) | (d & m);
                end
                `OFS_PER_GATE: begin
                    m = bmask & `PER_GATE_MASK;
                    if (state_ff.unlock != ULK_OPEN) begin
                        m[`POS_WDT] = 1'b0;
                    end
                    nxt_state.per_gate = (state_ff.per_gate & ~m) | (d & m);
                end
                `OFS_STATUS: begin
                    clr_fail = state_ff.w_strb[0] && d[`POS_FAIL];
                end
                `OFS_SEL0: begin
                    if (state_ff.w_strb[0] && state_ff.unlock == ULK_OPEN) begin
                        ck = core_check(d[2:0], state_ff.stable);
                        if (ck == 2'b11) begin
                            nxt_state.core_sel = d[2:0];
                        end
                        set_fail = ck == 2'b10;
                        ck = tick_check(d[5:3], state_ff.stable);
                        if (ck == 2'b11) begin
                            nxt_state.tick_sel = d[5:3];
                        end
                        set_fail = set_fail || ck == 2'b10;
                    end
                end
                `OFS_SEL1: begin
                    if (state_ff.w_strb[3]) begin
                        ck = pwm_check(d[29:28], state_ff.stable);
                        if (ck == 2'b11) begin
                            nxt_state.pwm0_sel = d[29:28];
                        end
                        set_fail = ck == 2'b10;
                        ck = pwm_check(d[31:30], state_ff.stable);
                        if (ck == 2'b11) begin
                            nxt_state.pwm1_sel = d[31:30];
                        end
                        set_fail = set_fail || ck == 2'b10;
                    end
                end
                `OFS_UNLOCK: begin
                    if (state_ff.w_strb[0]) begin
                        unique case (state_ff.unlock)
                            ULK_IDLE, ULK_KEY2, ULK_OPEN: begin
                                nxt_state.unlock = ULK_IDLE;
                                if (state_ff.unlock == ULK_KEY2 && d[7:0] == `KEY_3) begin
                                    nxt_state.unlock = ULK_OPEN;
                                end else if (d[7:0] == `KEY_1) begin
                                    nxt_state.unlock = ULK_KEY1;
                                end
                            end
                            ULK_KEY1: begin
                                nxt_state.unlock = (d[7:0] == `KEY_2) ? ULK_KEY2 : ULK_IDLE;
                            end
                            default: nxt_state.unlock = ULK_IDLE;
                        endcase
                    end
                end
                default: nxt_state.bresp = `RESP_SLVERR;
            endcase
        end
        // set wins over a clear in the same cycle
        nxt_state.fail = (state_ff.fail && !clr_fail) || set_fail;

        // read decode, reserved bits read zero
        unique case (araddr[11:0])
            `OFS_BUS_GATE: rd_word = state_ff.bus_gate;
            `OFS_PER_GATE: rd_word = state_ff.per_gate;
            `OFS_STATUS: rd_word = {24'h00_0000, state_ff.fail, 2'b00,
                                    state_ff.stable[3:1], 1'b0,
                                    state_ff.stable[0]};
            `OFS_SEL0: rd_word = {26'h000_0000, state_ff.tick_sel, state_ff.core_sel};
            `OFS_SEL1: rd_word = {state_ff.pwm1_sel, state_ff.pwm0_sel, 28'h000_0000};
            `OFS_UNLOCK: rd_word = {31'h0000_0000, state_ff.unlock == ULK_OPEN};
            default: rd_hit = 1'b0;
        endcase
        if (state_ff.rvalid && rready) begin
            nxt_state.rvalid = 1'b0;
        end
        if (arvalid && !state_ff.rvalid) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata = rd_word;
            nxt_state.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    always_comb begin
        fail_event = nxt_state.fail && !state_ff.fail;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
            state_ff.bus_gate <= `BUS_GATE_RST;
            state_ff.per_gate <= `PER_GATE_RST;
            state_ff.core_sel <= boot_clock_config;
            state_ff.tick_sel <= `TICK_SEL_RST;
            state_ff.pwm0_sel <= `PWM_SEL_RST;
            state_ff.pwm1_sel <= `PWM_SEL_RST;
            state_ff.unlock <= ULK_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; gate levels feed glitch-free latch gates downstream

    assign awready = !state_ff.aw_held;
    assign wready = !state_ff.w_held;
    assign bvalid = state_ff.bvalid;
    assign bresp = state_ff.bresp;
    assign arready = !state_ff.rvalid;
    assign rvalid = state_ff.rvalid;
    assign rdata = state_ff.rdata;
    assign rresp = state_ff.rresp;

    assign ext_bus_ctrl_clk_on = state_ff.bus_gate[`POS_EXT_BUS];
    assign flash_prog_clk_on = state_ff.bus_gate[`POS_FLASH];
    assign adc_clk_on = state_ff.per_gate[`POS_ADC];
    assign pwm_pair_clk_on = state_ff.per_gate[`POS_PWM0 +: 4];
    assign serial1_clk_on = state_ff.per_gate[`POS_SER0 + 1];
    assign serial0_clk_on = state_ff.per_gate[`POS_SER0];
    assign spi_ctrl1_clk_on = state_ff.per_gate[`POS_SPI0 + 1];
    assign spi_ctrl0_clk_on = state_ff.per_gate[`POS_SPI0];
    assign i2c_clk_on = state_ff.per_gate[`POS_I2C];
    assign freq_divider_clk_on = state_ff.per_gate[`POS_FDIV];
    assign timer_clk_on = state_ff.per_gate[`POS_TMR0 +: 4];
    assign watchdog_clk_on = state_ff.per_gate[`POS_WDT];
    assign core_src_sel = state_ff.core_sel;
    assign tick_src_sel = state_ff.tick_sel;
    assign pwm_pair0_src_sel = state_ff.pwm0_sel;
    assign pwm_pair1_src_sel = state_ff.pwm1_sel;
    assign switch_fail_flag = state_ff.fail;
    assign regs_unlocked = state_ff.unlock == ULK_OPEN;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wr_bus;
    logic wr_per;
    assign wr_bus = do_wr && state_ff.aw_addr == `OFS_BUS_GATE;
    assign wr_per = do_wr && state_ff.aw_addr == `OFS_PER_GATE;

    // select writes that get past the protection and strobe checks
    logic wr_sel0;
    logic wr_sel1;
    assign wr_sel0 = do_wr && state_ff.aw_addr == `OFS_SEL0 && state_ff.w_strb[0] &&
        regs_unlocked;
    assign wr_sel1 = do_wr && state_ff.aw_addr == `OFS_SEL1 && state_ff.w_strb[3];

    AST_EXT_BUS_GATE: assert property (wr_bus && state_ff.w_strb[0] |=>
        ext_bus_ctrl_clk_on == $past(state_ff.w_data[3]))
        else $error("external bus clock gate did not follow write");
    AST_FLASH_GATE: assert property (wr_bus && state_ff.w_strb[0] |=>
        flash_prog_clk_on == $past(state_ff.w_data[2]))
        else $error("flash clock gate did not follow write");
    AST_ADC_GATE: assert property (wr_per && state_ff.w_strb[3] |=>
        adc_clk_on == $past(state_ff.w_data[28]))
        else $error("converter clock gate did not follow write");
    AST_PWM_GATE: assert property (wr_per && state_ff.w_strb[2] |=>
        pwm_pair_clk_on == $past(state_ff.w_data[23:20]))
        else $error("pwm pair gates did not follow write");
    AST_SERIAL_GATE: assert property (wr_per && state_ff.w_strb[2] |=>
        {serial1_clk_on, serial0_clk_on} == $past(state_ff.w_data[17:16]))
        else $error("serial gates did not follow write");
    AST_SPI_I2C_GATE: assert property (wr_per && state_ff.w_strb[1] |=>
        {spi_ctrl1_clk_on, spi_ctrl0_clk_on, i2c_clk_on} ==
        {$past(state_ff.w_data[13:12]), $past(state_ff.w_data[8])})
        else $error("spi or i2c gate did not follow write");
    AST_FDIV_GATE: assert property (wr_per && state_ff.w_strb[0] |=>
        freq_divider_clk_on == $past(state_ff.w_data[6]))
        else $error("divider gate did not follow write");
    AST_TIMER_GATE: assert property (wr_per && state_ff.w_strb[0] |=>
        timer_clk_on == $past(state_ff.w_data[5:2]))
        else $error("timer gates did not follow write");
    AST_WDT_LOCKED: assert property (wr_per && !regs_unlocked |=>
        $stable(watchdog_clk_on))
        else $error("watchdog gate changed while locked");
    AST_FAIL_SET: assert property (wr_sel0 && state_ff.w_data[2:0] == 3'b000 &&
        !state_ff.stable[0] |=> switch_fail_flag)
        else $error("switch fail flag not set");
    AST_FAIL_CLEAR: assert property (do_wr && state_ff.aw_addr == `OFS_STATUS &&
        state_ff.w_strb[0] && state_ff.w_data[`POS_FAIL] |=>
        !switch_fail_flag)
        else $error("switch fail flag not cleared by write one");
    AST_STATUS: assert property (arvalid && arready && araddr[11:0] == `OFS_STATUS |=>
        rdata[4:0] == {$past(fast_rc_stable, 2), $past(slow_rc_stable, 2),
        $past(pll_locked_flag, 2), 1'b0, $past(crystal_stable, 2)})
        else $error("status bits do not show the oscillator levels");
    AST_KEEP_SOURCE: assert property (wr_sel0 && state_ff.w_data[2:0] == 3'b000 &&
        !state_ff.stable[0] |=> $stable(core_src_sel))
        else $error("core source switched although target unstable");
    AST_KEEP_PAIR0: assert property (wr_sel1 && state_ff.w_data[29:28] == 2'b00 &&
        !state_ff.stable[0] |=> $stable(pwm_pair0_src_sel))
        else $error("pwm pair 0 source switched although target unstable");
    AST_CORE_APPLY: assert property (wr_sel0 && state_ff.w_data[2:0] == 3'b010 &&
        state_ff.stable[1] |=> core_src_sel == 3'b010)
        else $error("core source did not take the stable pll");
    AST_TICK_APPLY: assert property (wr_sel0 && state_ff.w_data[5:3] == 3'b011 |=>
        tick_src_sel == 3'b011)
        else $error("tick source did not take the halved core clock");
    AST_PAIR1_APPLY: assert property (wr_sel1 && state_ff.w_data[31:30] == 2'b10 |=>
        pwm_pair1_src_sel == 2'b10)
        else $error("pwm pair 1 source did not take the core clock");
    AST_RESERVED_SEL: assert property (wr_sel0 && state_ff.w_data[2:0] == 3'b001 |=>
        $stable(core_src_sel))
        else $error("core source switched on a reserved code");
    AST_BOOT_SEL: assert property (disable iff (1'b0) !aresetn |=>
        core_src_sel == $past(boot_clock_config))
        else $error("core source not loaded from boot configuration");

    COV_WRITE: cover property (bvalid && bready && bresp == `RESP_OKAY);
    COV_READ: cover property (rvalid && rready);
    COV_FAIL: cover property (fail_event);
    COV_UNLOCK: cover property ($rose(regs_unlocked));

endmodule : clock_gate_and_source_select

//--- tb/clock_gate_and_source_select_test.sv
// self-checking bench of the clock gate and source select block
`timescale 1ns/10ps
`include "clk_gate_regs.svh"

module clock_gate_and_source_select_test;

logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [11:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rdata, rd_v, exp_per, d;
logic [3:0] wstrb = 0, pwm_pair_clk_on, timer_clk_on, st;
logic [1:0] bresp, rresp, pwm_pair0_src_sel, pwm_pair1_src_sel, rsp;
logic awready, wready, bvalid, arready, rvalid, exp_fail;
logic crystal_stable = 1, fast_rc_stable = 1, slow_rc_stable = 1, pll_locked_flag = 1;
logic [2:0] boot_clock_config = 0, core_src_sel, tick_src_sel, boot, c;
logic [2:0] exp_core, exp_tick, exp_p0, exp_p1;
logic ext_bus_ctrl_clk_on, flash_prog_clk_on, adc_clk_on, serial1_clk_on, serial0_clk_on;
logic spi_ctrl1_clk_on, spi_ctrl0_clk_on, i2c_clk_on, freq_divider_clk_on, watchdog_clk_on;
logic switch_fail_flag, regs_unlocked;
int err_total = 0, checked = 0, seed = 32'h0000_10f0;
wire [15:0] gate_out = {adc_clk_on, pwm_pair_clk_on, serial1_clk_on, serial0_clk_on,
    spi_ctrl1_clk_on, spi_ctrl0_clk_on, i2c_clk_on, freq_divider_clk_on, timer_clk_on,
    watchdog_clk_on};

always #20 aclk = ~aclk;

clock_gate_and_source_select DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .crystal_stable, .fast_rc_stable, .slow_rc_stable,
    .pll_locked_flag, .boot_clock_config, .ext_bus_ctrl_clk_on, .flash_prog_clk_on,
    .adc_clk_on, .pwm_pair_clk_on, .serial1_clk_on, .serial0_clk_on, .spi_ctrl1_clk_on,
    .spi_ctrl0_clk_on, .i2c_clk_on, .freq_divider_clk_on, .timer_clk_on, .watchdog_clk_on,
    .core_src_sel, .tick_src_sel, .pwm_pair0_src_sel, .pwm_pair1_src_sel, .switch_fail_flag,
    .regs_unlocked);

////////////////////////////////////////////////
task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask : complete_run

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
        err_total++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask : chk

task automatic chkb(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
        err_total++;
        $display("wrong value %s expected %b seen %b", nm, e, g);
    end
endtask : chkb

task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s);
    bit ad = 0;
    bit wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
        @(posedge aclk);
        if (awready) ad = 1;
        if (wready) wd = 1;
        if (ad) awvalid <= 0;
        if (wd) wvalid <= 0;
    end
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 0;
endtask : wr

task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rd_v = rdata;
    rsp = rresp;
    rready <= 0;
endtask : rd

task automatic unlock(input logic [7:0] k3);
    wr(`OFS_UNLOCK, {24'h0, `KEY_1}, 4'h1);
    wr(`OFS_UNLOCK, {24'h0, `KEY_2}, 4'h1);
    wr(`OFS_UNLOCK, {24'h0, k3}, 4'h1);
endtask : unlock

////////////////////////////////////////////////
// kind 0 core, 1 tick, 2 pwm pair
function automatic logic ok(input int kind, input logic [2:0] k);
    if (k[2]) return fast_rc_stable;
    if (kind == 2 && k == 3'h3) return fast_rc_stable;
    if (k == 3'h0 || (kind == 1 && k == 3'h2)) return crystal_stable;
    if (kind == 0 && k == 3'h2) return pll_locked_flag;
    if (kind == 0) return slow_rc_stable;
    return 1'b1;
endfunction : ok

function automatic logic [15:0] pv(input logic [31:0] e);
    return {e[28], e[23:20], e[17:16], e[13:12], e[8], e[6], e[5:2], e[0]};
endfunction : pv

task automatic apply(inout logic [2:0] cur, input int kind, input logic [2:0] k);
    if (k == 3'h1) return;
    if (ok(kind, k)) cur = k;
    else exp_fail = 1;
endtask : apply

task automatic check_sel();
    chk("core_sel", 32'(exp_core), 32'(core_src_sel));
    chk("tick_sel", 32'(exp_tick), 32'(tick_src_sel));
    chk("pair0_sel", 32'(exp_p0), 32'(pwm_pair0_src_sel));
    chk("pair1_sel", 32'(exp_p1), 32'(pwm_pair1_src_sel));
    chkb("fail", exp_fail, switch_fail_flag);
    rd(`OFS_STATUS);
    chk("status", {24'h0, exp_fail, 2'h0, fast_rc_stable, slow_rc_stable, pll_locked_flag,
        1'b0, crystal_stable}, rd_v);
    rd(`OFS_SEL0);
    chk("sel0_rd", {26'h0, exp_tick, exp_core}, rd_v);
    rd(`OFS_SEL1);
    chk("sel1_rd", {exp_p1[1:0], exp_p0[1:0], 28'h0}, rd_v);
endtask : check_sel

task automatic try(input bit s1, input logic [2:0] a, input logic [2:0] b);
    if (s1) begin
        wr(`OFS_SEL1, {a[1:0], b[1:0], 28'h0}, 4'h8);
        apply(exp_p1, 2, a);
        apply(exp_p0, 2, b);
    end else begin
        unlock(`KEY_3);
        wr(`OFS_SEL0, {26'h0, a, b}, 4'h1);
        apply(exp_tick, 1, a);
        apply(exp_core, 0, b);
    end
    check_sel();
endtask : try

task automatic do_reset(input logic [2:0] b);
    aresetn <= 0;
    boot_clock_config <= b;
    {crystal_stable, pll_locked_flag, slow_rc_stable, fast_rc_stable} <= 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    exp_core = b;
    exp_tick = 3'h7;
    exp_p0 = 3'h3;
    exp_p1 = 3'h3;
    exp_fail = 0;
    exp_per = 0;
    @(posedge aclk);
    chk("gates_rst", 32'h0, 32'(gate_out));
    check_sel();
    rd(`OFS_BUS_GATE);
    chk("bus_gate_rst", 32'h0000_000c, rd_v);
endtask : do_reset

////////////////////////////////////////////////
initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
end

initial begin
    boot = ($random(seed) & 1) ? 3'h7 : 3'h0;
    do_reset(boot);
    for (int i = 0; i < 6; i++) begin
        d = (i == 0) ? 32'h0 : $random(seed);
        wr(`OFS_BUS_GATE, d, 4'hf);
        chkb("ext_bus_on", d[3], ext_bus_ctrl_clk_on);
        chkb("flash_on", d[2], flash_prog_clk_on);
    end
    for (int i = 0; i < 10; i++) begin
        d = (i == 1) ? 32'hffff_ffff : ((i == 0) ? 32'h0 : $random(seed));
        wr(`OFS_PER_GATE, d, 4'hf);
        exp_per = (d & `PER_GATE_MASK & ~32'h1) | (exp_per & 32'h1);
        chk("gates", 32'(pv(exp_per)), 32'(gate_out));
        rd(`OFS_PER_GATE);
        chk("per_rd", exp_per, rd_v);
    end
    // bad third key keeps the watchdog gate locked
    unlock(8'h00);
    chkb("unlocked", 1'b0, regs_unlocked);
    wr(`OFS_PER_GATE, exp_per ^ 32'h1, 4'hf);
    chkb("wdt_on", exp_per[0], watchdog_clk_on);
    unlock(`KEY_3);
    chkb("unlocked", 1'b1, regs_unlocked);
    exp_per = exp_per ^ 32'h1;
    wr(`OFS_PER_GATE, exp_per, 4'hf);
    chkb("wdt_on", exp_per[0], watchdog_clk_on);
    // any unlock register write with byte 0 strobe relocks; the select write is then ignored
    wr(`OFS_UNLOCK, 32'h0, 4'h1);
    chkb("relocked", 1'b0, regs_unlocked);
    wr(`OFS_SEL0, {26'h0, 3'h3, 3'h2}, 4'h1);
    check_sel();
    for (int i = 0; i < 28; i++) begin
        st = (i == 0) ? 4'h7 : 4'($random(seed));
        c = (i == 0) ? 3'h0 : 3'($random(seed));
        if (i == 14) st = 4'hf;
        if (i == 14) c = 3'h2;
        if (i >= 14) st[2] = 1'b1;
        {crystal_stable, pll_locked_flag, slow_rc_stable, fast_rc_stable} <= st;
        if (i < 14) try(1'b0, 3'h3, c);
        else try(1'b0, c, 3'h2);
    end
    wr(`OFS_STATUS, 32'h0000_001f, 4'h1);
    check_sel();
    wr(`OFS_STATUS, 32'h0000_0080, 4'h1);
    exp_fail = 0;
    check_sel();
    {crystal_stable, pll_locked_flag, slow_rc_stable, fast_rc_stable} <= 4'hf;
    try(1'b1, 3'h2, 3'h2);
    for (int i = 0; i < 14; i++) begin
        {crystal_stable, pll_locked_flag, slow_rc_stable, fast_rc_stable} <= 4'($random(seed));
        c = {1'b0, 2'($random(seed))};
        if (i[0]) try(1'b1, c, 3'h2);
        else try(1'b1, 3'h2, c);
    end
    rd(12'h040);
    chk("rsp_rd", 32'(`RESP_SLVERR), 32'(rsp));
    chk("rd_unmapped", 32'h0, rd_v);
    wr(12'h040, 32'hffff_ffff, 4'hf);
    chk("rsp_wr", 32'(`RESP_SLVERR), 32'(rsp));
    chk("gates", 32'(pv(exp_per)), 32'(gate_out));
    check_sel();
    do_reset(boot ^ 3'h7);
    complete_run();
end

endmodule : clock_gate_and_source_select_test
